// ---- swc_consts.vh ----
// Constants for the sleep and wake-up controller: offsets, fields, codes and counts.
`ifndef SWC_CONSTS_VH
`define SWC_CONSTS_VH
`define SWC_ADDR_W 8
`define SWC_CTRL_OFS 8'h00
`define SWC_IRQEN_OFS 8'h04
`define SWC_STATUS_OFS 8'h08
`define SWC_CAUSE_OFS 8'h0C
`define SWC_CTRL_WDT_EN 0
`define SWC_CTRL_RST 1'h0
`define SWC_IRQ_N 3
`define SWC_IRQ_EXT 0
`define SWC_IRQ_PORT 1
`define SWC_IRQ_CMP 2
`define SWC_IRQEN_RST 3'h0
`define SWC_STAT_ASLEEP 0
`define SWC_STAT_HOLD 1
`define SWC_STAT_PD 3
`define SWC_STAT_TO 4
`define SWC_IO_W 8
`define SWC_PC_W 13
`define SWC_IRQ_VECTOR 13'h0004
`define SWC_OST_CYCLES 1024
`define SWC_OST_W 16
`define SWC_CAUSE_NONE 2'h0
`define SWC_CAUSE_WDT 2'h1
`define SWC_CAUSE_IRQ 2'h2
`define SWC_CAUSE_EXT 2'h3
`endif

// ---- swc_sync.v ----
// Two-flop synchroniser for pin inputs, one chain per bit.
`timescale 1ns/1ps
module swc_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire i_clock,
   input wire i_rst_n,
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg meta_r;
         reg sync_r;
         always @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               meta_r <= RST_VAL[g];
               sync_r <= RST_VAL[g];
            end else begin
               meta_r <= i_async[g];
               sync_r <= meta_r;
            end
         end
         assign o_sync[g] = sync_r;
      end
   endgenerate
endmodule

// ---- swc_top.v ----
// Sleep entry, wake-up and resume control with an APB register slave.
// Functional notes
// - Low-power state is entered only on the sleep instruction strobe.
// - Sleep entry with watchdog enabled clears its count; it keeps running.
// - Sleep entry clears the power-down flag and sets the time-out flag.
// - Sleep entry switches the oscillator driver off until wake-up.
// - Port pins keep their drive state throughout sleep.
// - A watchdog reset never drives the external reset pin low.
// - Wake on external reset pin, enabled watchdog time-out, or enabled interrupt.
// - Reset-pin wake resets the device; watchdog and interrupt wakes resume.
// - Power-down flag is set at power-up.
// - Watchdog wake-up clears the time-out flag.
// - During the sleep instruction the next instruction is prefetched.
// - Only individually enabled interrupts wake; global enable does not gate.
// - Interrupt wake with global enable clear continues after the sleep instruction.
// - With global enable set, run the prefetched instruction, then jump to vector.
// - An already pending enabled interrupt completes sleep then wakes at once.
// - Every wake-up from sleep clears the watchdog count.
// - Watchdog wake leaves flags 0,0; interrupt wake leaves them 1,0.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "swc_consts.vh"
module swc_top #(
   parameter P_OST_CYCLES = `SWC_OST_CYCLES
) (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`SWC_ADDR_W-1:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   input wire i_sleep_exec,
   input wire i_global_irq_enable,
   input wire [`SWC_IRQ_N-1:0] i_irq_flag,
   input wire i_wdt_timeout,
   input wire i_external_reset_pin_n,
   input wire [`SWC_IO_W-1:0] i_port_drive,
   input wire [`SWC_IO_W-1:0] i_port_oe_n,
   output reg [`SWC_IO_W-1:0] o_port_drive,
   output reg [`SWC_IO_W-1:0] o_port_oe_n,
   output reg o_external_reset_pin_out,
   output reg o_external_reset_pin_oe_n,
   output reg o_wdt_enable,
   output reg o_wdt_clear,
   output reg o_osc_enable,
   output reg o_exec_hold,
   output reg o_prefetch_next,
   output reg o_resume,
   output reg o_vector_jump,
   output reg [`SWC_PC_W-1:0] o_vector_addr,
   output reg o_core_reset_n,
   output reg o_timeout_flag,
   output reg o_powerdown_flag,
   output reg o_asleep
);
   localparam [2:0] ST_AWAKE = 3'h0;
   localparam [2:0] ST_SLEEP = 3'h1;
   localparam [2:0] ST_OST = 3'h2;
   localparam [2:0] ST_RESUME = 3'h3;
   localparam [2:0] ST_VECTOR = 3'h4;
   // The start-up count must fit the counter width; larger settings would wrap.
   localparam integer OST_LAST_I = P_OST_CYCLES - 1;
   localparam [`SWC_OST_W-1:0] OST_LAST = OST_LAST_I[`SWC_OST_W-1:0];

   function sel_hit;
      input [`SWC_ADDR_W-1:0] addr;
      input [`SWC_ADDR_W-1:0] ofs;
      begin
         sel_hit = (addr == ofs);
      end
   endfunction

   // Only a pin wake restarts the core; the other causes go on from the prefetch.
   function cause_resumes;
      input [1:0] cause;
      begin
         cause_resumes = (cause != `SWC_CAUSE_EXT);
      end
   endfunction

   wire ext_pin_n;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [`SWC_OST_W-1:0] ost_cnt_r;
   reg [`SWC_OST_W-1:0] ost_cnt_nxt;
   reg [1:0] cause_r;
   reg [1:0] cause_nxt;
   reg wdt_en_r;
   reg [`SWC_IRQ_N-1:0] irq_en_r;
   reg to_nxt;
   reg pd_nxt;
   reg wdt_clear_nxt;
   reg osc_nxt;
   reg hold_nxt;
   reg resume_nxt;
   reg vector_nxt;
   reg core_rst_n_nxt;
   reg [31:0] rdata_nxt;
   reg slverr_nxt;
   wire irq_wake;
   wire apb_setup;
   wire apb_wr;
   wire ports_live;
   wire wdt_fire;

   swc_sync #(
      .W(1),
      .RST_VAL(1'b1)
   ) u_pin_sync (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_async(i_external_reset_pin_n),
      .o_sync(ext_pin_n)
   );

   // The global enable is deliberately absent here; it only steers the resume path.
   assign irq_wake = |(i_irq_flag & irq_en_r);
   // A time-out pulse only counts while the watchdog is enabled.
   assign wdt_fire = wdt_en_r & i_wdt_timeout;
   assign apb_setup = i_psel & ~i_penable & ~o_pready;
   assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;
   assign ports_live = (state_r == ST_AWAKE) | (state_r == ST_RESUME) |
                       (state_r == ST_VECTOR);

   always @* begin
      state_nxt = state_r;
      ost_cnt_nxt = ost_cnt_r;
      cause_nxt = cause_r;
      to_nxt = o_timeout_flag;
      pd_nxt = o_powerdown_flag;
      wdt_clear_nxt = 1'b0;
      osc_nxt = o_osc_enable;
      hold_nxt = o_exec_hold;
      resume_nxt = 1'b0;
      vector_nxt = 1'b0;
      core_rst_n_nxt = ext_pin_n;
      case (state_r)
         ST_AWAKE: begin
            osc_nxt = 1'b1;
            hold_nxt = 1'b0;
            if (!ext_pin_n) begin
               // A pin reset while running leaves the status flags as they were.
               cause_nxt = `SWC_CAUSE_NONE;
            end else if (wdt_fire) begin
               // Watchdog reset while running: core reset only, the pin stays released.
               core_rst_n_nxt = 1'b0;
               wdt_clear_nxt = 1'b1;
               to_nxt = 1'b0;
            end else if (i_sleep_exec) begin
               state_nxt = ST_SLEEP;
               wdt_clear_nxt = wdt_en_r;
               pd_nxt = 1'b0;
               to_nxt = 1'b1;
               osc_nxt = 1'b0;
               hold_nxt = 1'b1;
               cause_nxt = `SWC_CAUSE_NONE;
            end
         end
         ST_SLEEP: begin
            // A pending enabled interrupt is seen here, one cycle after entry,
            // so the sleep instruction has already completed before the wake.
            if (!ext_pin_n) begin
               state_nxt = ST_OST;
               cause_nxt = `SWC_CAUSE_EXT;
               to_nxt = 1'b1;
               pd_nxt = 1'b0;
            end else if (wdt_fire) begin
               state_nxt = ST_OST;
               cause_nxt = `SWC_CAUSE_WDT;
               to_nxt = 1'b0;
               pd_nxt = 1'b0;
            end else if (irq_wake) begin
               state_nxt = ST_OST;
               cause_nxt = `SWC_CAUSE_IRQ;
               to_nxt = 1'b1;
               pd_nxt = 1'b0;
            end
            if (state_nxt == ST_OST) begin
               wdt_clear_nxt = 1'b1;
               osc_nxt = 1'b1;
               ost_cnt_nxt = OST_LAST;
            end
         end
         ST_OST: begin
            hold_nxt = 1'b1;
            // A pin reset during start-up wins over the pending resume.
            if (!ext_pin_n && cause_resumes(cause_r)) begin
               state_nxt = ST_AWAKE;
               hold_nxt = 1'b0;
            end else if (ost_cnt_r == {`SWC_OST_W{1'b0}}) begin
               hold_nxt = 1'b0;
               if (!cause_resumes(cause_r)) begin
                  state_nxt = ST_AWAKE;
               end else begin
                  state_nxt = ST_RESUME;
                  resume_nxt = 1'b1;
               end
            end else begin
               ost_cnt_nxt = ost_cnt_r - 1'b1;
            end
         end
         ST_RESUME: begin
            // The prefetched instruction runs now; the vector follows only with
            // global enable set, otherwise execution simply carries on in line.
            if (!ext_pin_n) begin
               state_nxt = ST_AWAKE;
            end else if (cause_r == `SWC_CAUSE_IRQ && i_global_irq_enable) begin
               state_nxt = ST_VECTOR;
               vector_nxt = 1'b1;
            end else begin
               state_nxt = ST_AWAKE;
            end
         end
         ST_VECTOR: begin
            state_nxt = ST_AWAKE;
         end
         default: begin
            // An unused state code recovers to awake with the clock running.
            state_nxt = ST_AWAKE;
            osc_nxt = 1'b1;
            hold_nxt = 1'b0;
         end
      endcase
   end

   always @* begin
      rdata_nxt = 32'h00000000;
      slverr_nxt = 1'b0;
      if (sel_hit(i_paddr, `SWC_CTRL_OFS)) begin
         rdata_nxt[`SWC_CTRL_WDT_EN] = wdt_en_r;
      end else if (sel_hit(i_paddr, `SWC_IRQEN_OFS)) begin
         rdata_nxt[`SWC_IRQ_N-1:0] = irq_en_r;
      end else if (sel_hit(i_paddr, `SWC_STATUS_OFS)) begin
         rdata_nxt[`SWC_STAT_ASLEEP] = o_asleep;
         rdata_nxt[`SWC_STAT_HOLD] = o_exec_hold;
         rdata_nxt[`SWC_STAT_PD] = o_powerdown_flag;
         rdata_nxt[`SWC_STAT_TO] = o_timeout_flag;
      end else if (sel_hit(i_paddr, `SWC_CAUSE_OFS)) begin
         rdata_nxt[1:0] = cause_r;
      end else begin
         slverr_nxt = 1'b1;
      end
   end

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
         wdt_en_r <= `SWC_CTRL_RST;
         irq_en_r <= `SWC_IRQEN_RST;
      end else begin
         // One cycle is spent in setup, so pready is high on the first access cycle.
         o_pready <= apb_setup;
         if (apb_setup) begin
            o_prdata <= i_pwrite ? 32'h00000000 : rdata_nxt;
            o_pslverr <= slverr_nxt;
         end else if (!i_psel) begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
         end
         // Writes to the status and cause words are ignored; they show live state.
         if (apb_wr && sel_hit(i_paddr, `SWC_CTRL_OFS)) begin
            wdt_en_r <= i_pwdata[`SWC_CTRL_WDT_EN];
         end
         if (apb_wr && sel_hit(i_paddr, `SWC_IRQEN_OFS)) begin
            irq_en_r <= i_pwdata[`SWC_IRQ_N-1:0];
         end
      end
   end

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ST_AWAKE;
         ost_cnt_r <= {`SWC_OST_W{1'b0}};
         cause_r <= `SWC_CAUSE_NONE;
         o_timeout_flag <= 1'b1;
         o_powerdown_flag <= 1'b1;
         o_wdt_clear <= 1'b0;
         o_osc_enable <= 1'b1;
         o_exec_hold <= 1'b0;
         o_resume <= 1'b0;
         o_vector_jump <= 1'b0;
         o_core_reset_n <= 1'b0;
         o_prefetch_next <= 1'b0;
         o_asleep <= 1'b0;
         o_wdt_enable <= 1'b0;
         o_vector_addr <= `SWC_IRQ_VECTOR;
      end else begin
         state_r <= state_nxt;
         ost_cnt_r <= ost_cnt_nxt;
         cause_r <= cause_nxt;
         o_timeout_flag <= to_nxt;
         o_powerdown_flag <= pd_nxt;
         o_wdt_clear <= wdt_clear_nxt;
         o_osc_enable <= osc_nxt;
         o_exec_hold <= hold_nxt;
         o_resume <= resume_nxt;
         o_vector_jump <= vector_nxt;
         o_core_reset_n <= core_rst_n_nxt;
         // The prefetch fires only when the sleep instruction is really taken.
         o_prefetch_next <= (state_r == ST_AWAKE) & ext_pin_n & i_sleep_exec &
                            ~wdt_fire;
         o_asleep <= (state_nxt == ST_SLEEP);
         // The watchdog enable is passed on unchanged by sleep, so it keeps counting.
         o_wdt_enable <= wdt_en_r;
         o_vector_addr <= `SWC_IRQ_VECTOR;
      end
   end

   // Port drive is frozen from sleep entry until execution resumes; a hold of
   // this kind can only retain what the core drove on the cycle before sleep.
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_port_drive <= {`SWC_IO_W{1'b0}};
         o_port_oe_n <= {`SWC_IO_W{1'b1}};
      end else if (ports_live && state_nxt != ST_SLEEP) begin
         o_port_drive <= i_port_drive;
         o_port_oe_n <= i_port_oe_n;
      end else begin
         o_port_drive <= o_port_drive;
         o_port_oe_n <= o_port_oe_n;
      end
   end

   // The reset pin is input-only for this block, so no reset source can pull it low.
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_external_reset_pin_out <= 1'b0;
         o_external_reset_pin_oe_n <= 1'b1;
      end else begin
         o_external_reset_pin_out <= 1'b0;
         o_external_reset_pin_oe_n <= 1'b1;
      end
   end
endmodule

// ---- swc_properties.sv ----
// Concurrent checks on sleep entry and wake-up at the controller's ports.
`timescale 1ns/1ps
module swc_properties #(
   parameter P_OST_CYCLES = 4
) (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_sleep_exec,
   input wire i_wdt_timeout,
   input wire o_external_reset_pin_oe_n,
   input wire o_wdt_enable,
   input wire o_wdt_clear,
   input wire o_osc_enable,
   input wire o_exec_hold,
   input wire o_prefetch_next,
   input wire o_core_reset_n,
   input wire o_timeout_flag,
   input wire o_powerdown_flag,
   input wire o_asleep
);
   reg [15:0] hold_cnt_r;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   // A 16-bit counter lets the start-up wait be checked at any parameter value from 1 to 65535.
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_cnt_r <= 16'h0000;
      end else begin
         hold_cnt_r <= (o_exec_hold && !o_asleep) ? hold_cnt_r + 16'h0001 : 16'h0000;
      end
   end
   property p_entry_cause; $rose(o_asleep) |-> $past(i_sleep_exec); endproperty
   a_entry_cause: assert property (p_entry_cause) else $error("entry cause");
   property p_entry_wdt; $rose(o_asleep) && o_wdt_enable |-> o_wdt_clear; endproperty
   a_entry_wdt: assert property (p_entry_wdt) else $error("entry clear");
   property p_entry_flags;
      $rose(o_asleep) |-> !o_powerdown_flag && o_timeout_flag && o_exec_hold;
   endproperty
   a_entry_flags: assert property (p_entry_flags) else $error("entry flags");
   property p_osc_off; o_asleep |-> !o_osc_enable; endproperty
   a_osc_off: assert property (p_osc_off) else $error("osc on");
   property p_pin_free; o_external_reset_pin_oe_n; endproperty
   a_pin_free: assert property (p_pin_free) else $error("pin driven");
   property p_prefetch; o_prefetch_next |-> $rose(o_asleep); endproperty
   a_prefetch: assert property (p_prefetch) else $error("prefetch");
   property p_wake_clear; $fell(o_asleep) |-> o_wdt_clear && o_osc_enable; endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake clear");
   property p_wake_flags;
      $fell(o_asleep) |->
         !o_powerdown_flag && (o_timeout_flag == !($past(i_wdt_timeout) && $past(o_wdt_enable)));
   endproperty
   a_wake_flags: assert property (p_wake_flags) else $error("wake flags");
   property p_ost_len; $fell(o_exec_hold) |-> hold_cnt_r == P_OST_CYCLES; endproperty
   a_ost_len: assert property (p_ost_len) else $error("start-up wait");
   cover property ($fell(o_asleep) && !o_timeout_flag);
   cover property ($rose(o_exec_hold));
   cover property ($fell(o_core_reset_n) && o_exec_hold);
endmodule

// ---- swc_partner.sv ----
// Far-side model: watchdog counter and the reset pin's outside driver.
`timescale 1ns/1ps
module swc_partner #(
   parameter P_WDT_LIMIT = 40
) (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_wdt_enable,
   input wire i_wdt_clear,
   input wire i_pin_pull,
   output reg o_wdt_timeout,
   output wire o_external_reset_pin_n
);
   reg [15:0] count_r;
   // The pin rests high by its pull-up and drops only when the bench asks.
   assign o_external_reset_pin_n = !i_pin_pull;
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_r <= 16'h0000;
         o_wdt_timeout <= 1'b0;
      end else begin
         o_wdt_timeout <= i_wdt_enable && (count_r == P_WDT_LIMIT - 1);
         if (i_wdt_clear || !i_wdt_enable || count_r == P_WDT_LIMIT - 1) begin
            count_r <= 16'h0000;
         end else begin
            count_r <= count_r + 16'h0001;
         end
      end
   end
endmodule

// ---- tb_top.sv ----
// Bench: register access, sleep entry and every wake-up cause.
`timescale 1ns/1ps
`include "swc_consts.vh"
module tb_top;
   reg clk, rst_n, psel, pen, pwr, sleep, global_irq_enable, pull, err, seen;
   reg [7:0] paddr, pdrv, poe, ed, eo;
   reg [31:0] pwdata, rd;
   reg [2:0] irq;
   integer failures, comparisons, cycles, seed, i, n, r;
   wire [31:0] prdata;
   wire [7:0] pdo, poo;
   wire [12:0] vaddr;
   wire pready, pslverr, wdt_to, pin_n, wdt_en, wdt_clr, vjump, core_rst_n, resume, asleep;
   wire pin_out, pin_oe;
   swc_top #(.P_OST_CYCLES(4)) swc_top_inst (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_sleep_exec(sleep),
      .i_global_irq_enable(global_irq_enable), .i_irq_flag(irq), .i_wdt_timeout(wdt_to),
      .i_external_reset_pin_n(pin_n), .i_port_drive(pdrv), .i_port_oe_n(poe),
      .o_port_drive(pdo), .o_port_oe_n(poo), .o_external_reset_pin_out(pin_out),
      .o_external_reset_pin_oe_n(pin_oe), .o_wdt_enable(wdt_en), .o_wdt_clear(wdt_clr),
      .o_osc_enable(), .o_exec_hold(), .o_prefetch_next(), .o_resume(resume),
      .o_vector_jump(vjump), .o_vector_addr(vaddr), .o_core_reset_n(core_rst_n),
      .o_timeout_flag(), .o_powerdown_flag(), .o_asleep(asleep));
   swc_partner swc_partner_inst (.i_clock(clk), .i_rst_n(rst_n), .i_wdt_enable(wdt_en),
      .i_wdt_clear(wdt_clr), .i_pin_pull(pull), .o_wdt_timeout(wdt_to),
      .o_external_reset_pin_n(pin_n));
   function [31:0] stat_exp(input to, input pd);
      stat_exp = {27'h0, to, pd, 3'h0};
   endfunction
   task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwr <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         pen <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1) begin
            @(posedge clk);
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         pen <= 1'b0;
         @(posedge clk);
      end
   endtask
   task sleep_now;
      begin
         sleep <= 1'b1;
         @(posedge clk);
         sleep <= 1'b0;
         @(posedge clk);
      end
   endtask
   task wait_resume;
      begin
         n = 0;
         while (resume !== 1'b1 && n < 80) begin
            @(posedge clk);
            n = n + 1;
         end
         chk("resume", 1, resume);
         @(posedge clk);
      end
   endtask
   task close_out;
      begin
         if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
         end else begin
            $display("TESTS FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 6000) begin
         failures = failures + 1;
         close_out;
      end
   end
   initial begin
      failures = 0; comparisons = 0; cycles = 0; seed = 32'hF066;
      rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      sleep = 1'b0; global_irq_enable = 1'b0; pull = 1'b0; irq = 3'h0; pdrv = 8'h00; poe = 8'hFF;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(0, `SWC_STATUS_OFS, 0);
      chk("status", stat_exp(1'b1, 1'b1), rd);
      chk("vector", `SWC_IRQ_VECTOR, vaddr);
      apb(0, 8'h10, 0);
      chk("slverr", 1, err);
      for (i = 0; i < 6; i = i + 1) begin
         r = $random(seed);
         global_irq_enable <= r[8];
         pdrv <= r[7:0];
         poe <= r[16:9];
         apb(1, `SWC_IRQEN_OFS, 32'h1 << (i % 3));
         ed = pdrv;
         eo = poe;
         sleep_now;
         pdrv <= ~ed;
         poe <= ~eo;
         irq <= 3'h1 << ((i + 1) % 3);
         repeat (8) @(posedge clk);
         chk("asleep", 1, asleep);
         chk("port", ed, pdo);
         chk("port_oe", eo, poo);
         apb(0, `SWC_STATUS_OFS, 0);
         chk("slpstat", stat_exp(1'b1, 1'b0) | 32'h3, rd);
         irq <= irq | (3'h1 << (i % 3));
         wait_resume;
         irq <= 3'h0;
         chk("vjump", global_irq_enable, vjump);
         apb(0, `SWC_CAUSE_OFS, 0);
         chk("cause", `SWC_CAUSE_IRQ, rd);
      end
      global_irq_enable <= 1'b0;
      irq <= 3'h4;
      apb(1, `SWC_IRQEN_OFS, 32'h4);
      sleep_now;
      @(posedge clk);
      chk("asleep", 0, asleep);
      irq <= 3'h0;
      wait_resume;
      chk("vjump", 0, vjump);
      apb(1, `SWC_CTRL_OFS, 32'h1);
      apb(0, `SWC_CTRL_OFS, 0);
      chk("ctrl", 1, rd);
      sleep_now;
      wait_resume;
      apb(1, `SWC_CTRL_OFS, 0);
      apb(0, `SWC_STATUS_OFS, 0);
      chk("status", stat_exp(1'b0, 1'b0), rd);
      sleep_now;
      pull <= 1'b1;
      n = 0;
      while (core_rst_n !== 1'b0 && n < 10) begin
         @(posedge clk);
         n = n + 1;
      end
      chk("corerst", 0, core_rst_n);
      pull <= 1'b0;
      seen = 1'b0;
      repeat (20) begin
         @(posedge clk);
         seen = seen | (resume === 1'b1);
      end
      chk("noresume", 0, seen);
      apb(0, `SWC_CAUSE_OFS, 0);
      chk("cause", `SWC_CAUSE_EXT, rd);
      apb(1, `SWC_CTRL_OFS, 32'h1);
      n = 0;
      while (core_rst_n !== 1'b0 && n < 100) begin
         @(posedge clk);
         n = n + 1;
      end
      chk("wdtrst", 0, core_rst_n);
      chk("pin_oe", 1, pin_oe);
      chk("pin_out", 0, pin_out);
      apb(1, `SWC_CTRL_OFS, 0);
      apb(0, `SWC_STATUS_OFS, 0);
      chk("status", stat_exp(1'b0, 1'b0), rd);
      close_out;
   end
endmodule
bind swc_top swc_properties #(.P_OST_CYCLES(P_OST_CYCLES)) swc_properties_inst (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sleep_exec(i_sleep_exec),
   .i_wdt_timeout(i_wdt_timeout), .o_external_reset_pin_oe_n(o_external_reset_pin_oe_n),
   .o_wdt_enable(o_wdt_enable), .o_wdt_clear(o_wdt_clear), .o_osc_enable(o_osc_enable),
   .o_exec_hold(o_exec_hold), .o_prefetch_next(o_prefetch_next),
   .o_core_reset_n(o_core_reset_n), .o_timeout_flag(o_timeout_flag),
   .o_powerdown_flag(o_powerdown_flag), .o_asleep(o_asleep));
